/* rtos_map.svh */
// Register offsets, field positions, reset values of the real-time output block
// Assumes byte addresses on an 8-bit APB address, one 32-bit word per register
`ifndef RTOS_MAP_SVH
`define RTOS_MAP_SVH

// Register byte offsets
`define RTOS_OFS_CTRL    8'h00
`define RTOS_OFS_MODE    8'h04
`define RTOS_OFS_BUFL    8'h08
`define RTOS_OFS_BUFH    8'h0C
`define RTOS_OFS_SEC     8'h10
`define RTOS_OFS_PDATA   8'h14
`define RTOS_OFS_PDIR    8'h18
`define RTOS_OFS_PMC     8'h1C
`define RTOS_OFS_PPU     8'h20
`define RTOS_OFS_PFC     8'h24
`define RTOS_OFS_PF      8'h28
`define RTOS_OFS_FLTCFG  8'h2C
`define RTOS_OFS_STAT    8'h30

// Control register fields
`define RTOS_CTRL_OE     7
`define RTOS_CTRL_EDGE   6
`define RTOS_CTRL_CFG    5
`define RTOS_CTRL_SEL    4

// Security register fields
`define RTOS_SEC_ARM     2
`define RTOS_SEC_KEEP    3

// Fault edge configuration fields
`define RTOS_FLT_RISE    0
`define RTOS_FLT_FALL    1

// Reset values
`define RTOS_RST_CTRL    8'h00
`define RTOS_RST_SEC     4'h1
`define RTOS_RST_MODE    6'h00
`define RTOS_RST_PDATA   6'h00
`define RTOS_RST_PDIR    6'h3F
`define RTOS_RST_PMC     6'h00
`define RTOS_RST_PPU     6'h00
`define RTOS_RST_PFC     6'h00
`define RTOS_RST_PF      6'h00
`define RTOS_RST_FLTCFG  2'h0

`endif

/* rtos_pkg.sv */
// Types shared by the real-time output block
// Assumes the constants of rtos_map.svh
package rtos_pkg;
	typedef logic [5:0]  rtos_pins_type;
	typedef logic [31:0] rtos_word_type;
	typedef logic [7:0]  rtos_addr_type;
	typedef enum logic {
		RTOS_SPLIT,
		RTOS_SIX
	} rtos_chan_type;
endpackage

/* rtos_edge_det.sv */
// Edge detector with selectable rising and falling edges
// Assumes the input is synchronous to clk
`timescale 1ns/100ps
module rtos_edge_det (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic sigIn,
	input  wire logic riseEn,
	input  wire logic fallEn,
	output logic      edgePulse
);
	logic prev_q;

	// Previous level
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= sigIn;
		end
	end

	assign edgePulse = (riseEn & sigIn & ~prev_q) | (fallEn & ~sigIn & prev_q);
endmodule

/* rtos_top.sv */
// Real-time output port with security cut-off, APB register slave
// Assumes synchronous trigger inputs and a pin wrapper resolving pinOut/pinOe
// Functional notes
// - With output disabled, buffer writes go straight into the output latches.
// - With output enabled, latches load buffers only on the selected trigger.
// - Internal outputs reach pins only when mode and function control select them.
// - Armed security forces all six pins to high impedance on a fault edge.
// - The forced high impedance holds whatever the port configuration is.
// - A security event resets the six pins' bits in all port registers.
// - Security arm bit one uses fault pin edges as trigger, zero disables.
// - Security control register is byte/bit accessible, resets to 01H.
// - Clearing the arm bit ends the fault and unlocks port setting.
// - Bits 4 to 7 of security register stay zero; bit 3 has no effect.
// - Enabled output drives latch bits whose mode is set, else 0.
// - Disabled output drives all six internal outputs to 0.
// - Trigger mapping by channel configuration and trigger select.
// - Edge select picks falling (0) or rising (1) 16-bit timer edge.
`timescale 1ns/100ps
`include "rtos_map.svh"
module rtos_top (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire rtos_pkg::rtos_addr_type paddr,
	input  wire rtos_pkg::rtos_word_type pwdata,
	output rtos_pkg::rtos_word_type      prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  timer16MatchEvent,
	input  wire logic                  timerAEvent,
	input  wire logic                  timerBEvent,
	input  wire logic                  externalFaultPin,
	input  wire rtos_pkg::rtos_pins_type pinIn,
	output rtos_pkg::rtos_pins_type      pinOut,
	output rtos_pkg::rtos_pins_type      pinOe,
	output rtos_pkg::rtos_pins_type      pinPullupEn,
	output rtos_pkg::rtos_pins_type      rtoSignals,
	output logic                       faultActive
);
	import rtos_pkg::*;

	// Register state
	logic [7:0]    ctrl_q;
	rtos_pins_type mode_q;
	logic [3:0]    bufL_q;
	logic [3:0]    bufH_q;
	logic [3:0]    latchL_q;
	logic [1:0]    latchH_q;
	logic [3:0]    sec_q;
	rtos_pins_type pdata_q;
	rtos_pins_type pdir_q;
	rtos_pins_type pmc_q;
	rtos_pins_type ppu_q;
	rtos_pins_type pfc_q;
	rtos_pins_type pf_q;
	logic [1:0]    fltCfg_q;
	logic          fault_q;
	rtos_pins_type rtoSig_q;
	rtos_word_type prdata_q;
	logic          slverr_q;

	// Decoded bus signals
	logic          setup;
	logic          wr;
	logic          selCtrl;
	logic          selMode;
	logic          selBufL;
	logic          selBufH;
	logic          selSec;
	logic          selPdata;
	logic          selPdir;
	logic          selPmc;
	logic          selPpu;
	logic          selPfc;
	logic          selPf;
	logic          selFlt;
	logic          selStat;
	logic          mapped;
	rtos_word_type rdMux;

	// Block signals
	logic          outEnable;
	rtos_chan_type chanMode;
	logic          trigSel;
	logic          t16Edge;
	logic          faultEdge;
	logic          faultSet;
	logic          trigH;
	logic          trigL;
	logic          bufLWe;
	logic          bufHWe;
	logic          portWe;
	logic          armClear;

	assign outEnable = ctrl_q[`RTOS_CTRL_OE];
	assign chanMode  = rtos_chan_type'(ctrl_q[`RTOS_CTRL_CFG]);
	assign trigSel   = ctrl_q[`RTOS_CTRL_SEL];

	// APB phases
	assign setup   = psel & ~penable;
	assign wr      = psel & penable & pwrite;
	assign pready  = psel & penable;
	assign pslverr = psel & penable & slverr_q;
	assign prdata  = prdata_q;

	// Address decode
	always_comb begin
		selCtrl  = 1'b0;
		selMode  = 1'b0;
		selBufL  = 1'b0;
		selBufH  = 1'b0;
		selSec   = 1'b0;
		selPdata = 1'b0;
		selPdir  = 1'b0;
		selPmc   = 1'b0;
		selPpu   = 1'b0;
		selPfc   = 1'b0;
		selPf    = 1'b0;
		selFlt   = 1'b0;
		selStat  = 1'b0;
		if (paddr == `RTOS_OFS_CTRL) begin
			selCtrl = 1'b1;
		end else if (paddr == `RTOS_OFS_MODE) begin
			selMode = 1'b1;
		end else if (paddr == `RTOS_OFS_BUFL) begin
			selBufL = 1'b1;
		end else if (paddr == `RTOS_OFS_BUFH) begin
			selBufH = 1'b1;
		end else if (paddr == `RTOS_OFS_SEC) begin
			selSec = 1'b1;
		end else if (paddr == `RTOS_OFS_PDATA) begin
			selPdata = 1'b1;
		end else if (paddr == `RTOS_OFS_PDIR) begin
			selPdir = 1'b1;
		end else if (paddr == `RTOS_OFS_PMC) begin
			selPmc = 1'b1;
		end else if (paddr == `RTOS_OFS_PPU) begin
			selPpu = 1'b1;
		end else if (paddr == `RTOS_OFS_PFC) begin
			selPfc = 1'b1;
		end else if (paddr == `RTOS_OFS_PF) begin
			selPf = 1'b1;
		end else if (paddr == `RTOS_OFS_FLTCFG) begin
			selFlt = 1'b1;
		end else if (paddr == `RTOS_OFS_STAT) begin
			selStat = 1'b1;
		end
	end

	assign mapped = selCtrl | selMode | selBufL | selBufH | selSec | selPdata | selPdir
		| selPmc | selPpu | selPfc | selPf | selFlt | selStat;

	// Read data; either buffer address returns both buffers
	always_comb begin
		rdMux = 32'h0000_0000;
		if (selCtrl) begin
			rdMux[7:0] = {ctrl_q[7:4], 4'h0};
		end else if (selMode) begin
			rdMux[5:0] = mode_q;
		end else if (selBufL | selBufH) begin
			rdMux[7:0] = {bufH_q, bufL_q};
		end else if (selSec) begin
			rdMux[3:0] = sec_q;
		end else if (selPdata) begin
			rdMux[5:0] = pdata_q;
		end else if (selPdir) begin
			rdMux[5:0] = pdir_q;
		end else if (selPmc) begin
			rdMux[5:0] = pmc_q;
		end else if (selPpu) begin
			rdMux[5:0] = ppu_q;
		end else if (selPfc) begin
			rdMux[5:0] = pfc_q;
		end else if (selPf) begin
			rdMux[5:0] = pf_q;
		end else if (selFlt) begin
			rdMux[1:0] = fltCfg_q;
		end else if (selStat) begin
			rdMux[0]     = fault_q;
			rdMux[13:8]  = rtoSig_q;
			rdMux[21:16] = pinIn;
			rdMux[27:24] = latchL_q;
			rdMux[29:28] = latchH_q;
		end
	end

	// Read data and error flag captured in the setup phase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata_q <= 32'h0000_0000;
			slverr_q <= 1'b0;
		end else if (setup) begin
			prdata_q <= pwrite ? 32'h0000_0000 : rdMux;
			slverr_q <= ~mapped;
		end
	end

	// Control and mode registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= `RTOS_RST_CTRL;
			mode_q <= `RTOS_RST_MODE;
		end else begin
			if (wr & selCtrl) begin
				ctrl_q <= {pwdata[7:4], 4'h0};
			end
			if (wr & selMode) begin
				mode_q <= pwdata[5:0];
			end
		end
	end

	// Buffer write enables per channel configuration
	assign bufLWe = wr & (selBufL | (chanMode == RTOS_SIX & selBufH));
	assign bufHWe = wr & (selBufH | (chanMode == RTOS_SIX & selBufL));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bufL_q <= 4'h0;
			bufH_q <= 4'h0;
		end else begin
			if (bufLWe) begin
				bufL_q <= pwdata[3:0];
			end
			if (bufHWe) begin
				bufH_q <= pwdata[7:4];
			end
		end
	end

	// 16-bit timer event edge
	rtos_edge_det u_t16_edge (
		.clk       (clk),
		.rst       (rst),
		.sigIn     (timer16MatchEvent),
		.riseEn    (ctrl_q[`RTOS_CTRL_EDGE]),
		.fallEn    (~ctrl_q[`RTOS_CTRL_EDGE]),
		.edgePulse (t16Edge)
	);

	// Transfer trigger selection
	always_comb begin
		trigH = 1'b0;
		trigL = 1'b0;
		case (chanMode)
			RTOS_SPLIT: begin
				trigH = trigSel ? timerAEvent : timerBEvent;
				trigL = trigSel ? t16Edge : timerAEvent;
			end
			RTOS_SIX: begin
				trigH = trigSel ? t16Edge : timerAEvent;
				trigL = trigH;
			end
			default: begin
				trigH = 1'b0;
				trigL = 1'b0;
			end
		endcase
	end

	// Output latches
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			latchL_q <= 4'h0;
			latchH_q <= 2'h0;
		end else if (~outEnable) begin
			if (bufLWe) begin
				latchL_q <= pwdata[3:0];
			end
			if (bufHWe) begin
				latchH_q <= pwdata[5:4];
			end
		end else begin
			if (trigL) begin
				latchL_q <= bufL_q;
			end
			if (trigH) begin
				latchH_q <= bufH_q[1:0];
			end
		end
	end

	// Internal real-time output signals
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rtoSig_q <= 6'h00;
		end else if (outEnable) begin
			rtoSig_q <= {latchH_q, latchL_q} & mode_q;
		end else begin
			rtoSig_q <= 6'h00;
		end
	end

	assign rtoSignals = rtoSig_q;

	// Fault pin edge
	rtos_edge_det u_fault_edge (
		.clk       (clk),
		.rst       (rst),
		.sigIn     (externalFaultPin),
		.riseEn    (fltCfg_q[`RTOS_FLT_RISE]),
		.fallEn    (fltCfg_q[`RTOS_FLT_FALL]),
		.edgePulse (faultEdge)
	);

	assign faultSet = faultEdge & sec_q[`RTOS_SEC_ARM];
	assign armClear = wr & selSec & ~pwdata[`RTOS_SEC_ARM];

	// Security register; upper bits held at zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sec_q <= `RTOS_RST_SEC;
		end else if (wr & selSec) begin
			sec_q <= pwdata[3:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fltCfg_q <= `RTOS_RST_FLTCFG;
		end else if (wr & selFlt) begin
			fltCfg_q <= pwdata[1:0];
		end
	end

	// Fault state; a new fault edge wins over the clearing write
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fault_q <= 1'b0;
		end else if (faultSet) begin
			fault_q <= 1'b1;
		end else if (armClear) begin
			fault_q <= 1'b0;
		end
	end

	assign faultActive = fault_q;

	// Port writes locked while the fault holds
	assign portWe = wr & ~fault_q;

	// Port configuration registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pdata_q <= `RTOS_RST_PDATA;
			pdir_q  <= `RTOS_RST_PDIR;
			pmc_q   <= `RTOS_RST_PMC;
			ppu_q   <= `RTOS_RST_PPU;
			pfc_q   <= `RTOS_RST_PFC;
			pf_q    <= `RTOS_RST_PF;
		end else if (faultSet) begin
			pdata_q <= `RTOS_RST_PDATA;
			pdir_q  <= `RTOS_RST_PDIR;
			pmc_q   <= `RTOS_RST_PMC;
			ppu_q   <= `RTOS_RST_PPU;
			pfc_q   <= `RTOS_RST_PFC;
			pf_q    <= `RTOS_RST_PF;
		end else begin
			if (portWe & selPdata) begin
				pdata_q <= pwdata[5:0];
			end
			if (portWe & selPdir) begin
				pdir_q <= pwdata[5:0];
			end
			if (portWe & selPmc) begin
				pmc_q <= pwdata[5:0];
			end
			if (portWe & selPpu) begin
				ppu_q <= pwdata[5:0];
			end
			if (portWe & selPfc) begin
				pfc_q <= pwdata[5:0];
			end
			if (portWe & selPf) begin
				pf_q <= pwdata[5:0];
			end
		end
	end

	// Per-pin multiplexer and drivers
	genvar i;
	generate
		for (i = 0; i < 6; i++) begin : g_pin
			logic rtoSel;
			logic drv;
			assign rtoSel = pmc_q[i] & ~pfc_q[i];
			assign drv    = rtoSel ? rtoSig_q[i] : pdata_q[i];
			assign pinOut[i] = drv;
			assign pinOe[i]  = ~fault_q & (rtoSel | ~pdir_q[i])
				& (~pf_q[i] | ~drv);
			assign pinPullupEn[i] = ppu_q[i] & ~fault_q;
		end
	endgenerate
endmodule

/* rtos_motor_model.sv */
// Stepping motor driver model on the six shared port pins
// Assumes pinOe is high while the block drives a pin
`timescale 1ns/100ps
module rtos_motor_model (
	input  wire logic                    clk,
	input  wire rtos_pkg::rtos_pins_type pinOut,
	input  wire rtos_pkg::rtos_pins_type pinOe,
	input  wire rtos_pkg::rtos_pins_type pinPullupEn,
	output rtos_pkg::rtos_pins_type      pinIn
);
	import rtos_pkg::*;
	rtos_pins_type last_q = 6'h00;
	// Remember the level last driven by the block; a released line keeps it
	always_ff @(posedge clk) begin
		last_q <= (pinOe & pinOut) | (~pinOe & last_q);
	end
	// Released lines show the inverse of the last driven level unless pulled up
	assign pinIn = (pinOe & pinOut) | (~pinOe & (pinPullupEn | ~last_q));
endmodule

/* rtos_top_assertions.sv */
// Port-level checks of the real-time output block
// Assumes binding to rtos_top and the offsets of rtos_map.svh
`timescale 1ns/100ps
`include "rtos_map.svh"
module rtos_top_assertions (
	input wire logic                    clk,
	input wire logic                    rst,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire rtos_pkg::rtos_addr_type paddr,
	input wire rtos_pkg::rtos_word_type pwdata,
	input wire rtos_pkg::rtos_word_type prdata,
	input wire logic                    pready,
	input wire logic                    pslverr,
	input wire logic                    externalFaultPin,
	input wire rtos_pkg::rtos_pins_type pinOe,
	input wire rtos_pkg::rtos_pins_type pinPullupEn,
	input wire rtos_pkg::rtos_pins_type rtoSignals,
	input wire logic                    faultActive
);
	import rtos_pkg::*;
	logic          outEn_q;
	logic          arm_q;
	rtos_pins_type mode_q;
	logic          wrAcc;
	logic          clrWr;
	assign wrAcc = psel && penable && pwrite;
	assign clrWr = wrAcc && paddr == `RTOS_OFS_SEC && !pwdata[`RTOS_SEC_ARM];
	// Shadow of the enable, mode and arm bits
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			outEn_q <= 1'b0;
			arm_q   <= 1'b0;
			mode_q  <= 6'h00;
		end else if (wrAcc) begin
			if (paddr == `RTOS_OFS_CTRL)
				outEn_q <= pwdata[`RTOS_CTRL_OE];
			if (paddr == `RTOS_OFS_SEC)
				arm_q <= pwdata[`RTOS_SEC_ARM];
			if (paddr == `RTOS_OFS_MODE)
				mode_q <= pwdata[5:0];
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence s_fault_kept;
		faultActive && !clrWr;
	endsequence
	sequence s_sec_read;
		psel && penable && !pwrite && paddr == `RTOS_OFS_SEC;
	endsequence
	a_fault_hiz: assert property (faultActive |-> pinOe == 6'h00)
		else $error("pins driven during fault");
	a_arm_gate: assert property ($rose(faultActive) |-> $past(arm_q))
		else $error("fault set while disarmed");
	a_fault_sticky: assert property (s_fault_kept |=> faultActive)
		else $error("fault dropped on its own");
	a_clear_unlock: assert property (faultActive && clrWr && $stable(externalFaultPin)
		|=> !faultActive)
		else $error("fault kept after disarm");
	a_regs_cleared: assert property ($fell(faultActive) |-> pinPullupEn == 6'h00)
		else $error("pull-ups survived fault");
	a_off_zero: assert property (!outEn_q |=> rtoSignals == 6'h00)
		else $error("outputs active while disabled");
	a_mode_mask: assert property ((rtoSignals & ~$past(mode_q)) == 6'h00)
		else $error("masked bit driven");
	a_sec_upper: assert property (s_sec_read |-> prdata[31:4] == '0)
		else $error("security upper bits set");
	a_apb_ready: assert property (psel && penable |-> pready)
		else $error("access phase without ready");
	a_unmapped_err: assert property (psel && penable && paddr > `RTOS_OFS_STAT
		|-> pslverr && (pwrite || prdata == '0))
		else $error("unmapped access accepted");
endmodule
bind rtos_top rtos_top_assertions u_checker (
	.clk(clk),
	.rst(rst),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.externalFaultPin(externalFaultPin),
	.pinOe(pinOe),
	.pinPullupEn(pinPullupEn),
	.rtoSignals(rtoSignals),
	.faultActive(faultActive)
);

/* rtos_top_test.sv */
// Self-checking bench of the real-time output block
// Assumes zero-wait APB and the offsets of rtos_map.svh
`timescale 1ns/100ps
`include "rtos_map.svh"
module rtos_top_test;
	import rtos_pkg::*;
	logic          clk = 1'b0;
	logic          rst = 1'b1;
	logic          psel = 1'b0;
	logic          penable = 1'b0;
	logic          pwrite = 1'b0;
	rtos_addr_type paddr = 8'h00;
	rtos_word_type pwdata = 32'h0;
	rtos_word_type prdata;
	rtos_word_type rd;
	logic          pready;
	logic          pslverr;
	logic          err;
	logic          t16 = 1'b0;
	logic          tmA = 1'b0;
	logic          tmB = 1'b0;
	logic          flt = 1'b0;
	rtos_pins_type pinIn;
	rtos_pins_type pinOut;
	rtos_pins_type pinOe;
	rtos_pins_type pinPu;
	rtos_pins_type rto;
	logic          fault;
	int            nFail = 0;
	int            nCompared = 0;
	rtos_top u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer16MatchEvent(t16), .timerAEvent(tmA), .timerBEvent(tmB),
		.externalFaultPin(flt), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
		.pinPullupEn(pinPu), .rtoSignals(rto), .faultActive(fault));
	rtos_motor_model u_motor (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
		.pinPullupEn(pinPu), .pinIn(pinIn));
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic check(input rtos_word_type seen, input rtos_word_type exp);
		nCompared++;
		if (seen !== exp) begin
			nFail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input rtos_addr_type a, input rtos_word_type d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input rtos_addr_type a, input rtos_word_type d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input rtos_addr_type a, input rtos_word_type exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	// Disable, zero both latches, enable with ctrl, then load 3F in both buffers
	task automatic arm_out(input rtos_word_type ctrl);
		wr(`RTOS_OFS_CTRL, 32'h0);
		wr(`RTOS_OFS_BUFL, 32'h0);
		wr(`RTOS_OFS_BUFH, 32'h0);
		wr(`RTOS_OFS_CTRL, ctrl);
		wr(`RTOS_OFS_BUFL, 32'h3F);
		wr(`RTOS_OFS_BUFH, 32'h3F);
		repeat (2) @(posedge clk);
	endtask
	task automatic test_regs;
		rdc(`RTOS_OFS_SEC, 32'h01);
		wr(`RTOS_OFS_SEC, 32'h0B);
		rdc(`RTOS_OFS_SEC, 32'h0B);
		rdc(8'h40, 32'h0);
		check({31'h0, err}, 32'h1);
		$display("registers done");
	endtask
	task automatic test_direct;
		wr(`RTOS_OFS_MODE, 32'h3F);
		wr(`RTOS_OFS_BUFL, 32'h05);
		wr(`RTOS_OFS_BUFH, 32'h20);
		rdc(`RTOS_OFS_BUFL, 32'h25);
		apb(1'b0, `RTOS_OFS_STAT, 32'h0);
		check(rd & 32'h3F00_0000, 32'h2500_0000);
		check({26'h0, rto}, 32'h0);
		$display("direct load done");
	endtask
	task automatic test_triggers;
		logic [5:0] exp [4][3] = '{'{6'h0F, 6'h30, 6'h00}, '{6'h30, 6'h00, 6'h0F},
			'{6'h3F, 6'h00, 6'h00}, '{6'h00, 6'h00, 6'h3F}};
		for (int c = 0; c < 4; c++) begin
			for (int k = 0; k < 3; k++) begin
				arm_out(32'hC0 | 32'(c << 4));
				check({26'h0, rto}, 32'h0);
				tmA <= (k == 0);
				tmB <= (k == 1);
				t16 <= (k == 2);
				@(posedge clk);
				tmA <= 1'b0;
				tmB <= 1'b0;
				t16 <= 1'b0;
				repeat (3) @(posedge clk);
				check({26'h0, rto}, {26'h0, exp[c][k]});
			end
		end
		$display("trigger mapping done");
	endtask
	task automatic test_edge;
		arm_out(32'hB0);
		t16 <= 1'b1;
		repeat (4) @(posedge clk);
		check({26'h0, rto}, 32'h0);
		t16 <= 1'b0;
		repeat (4) @(posedge clk);
		check({26'h0, rto}, 32'h3F);
		$display("timer edge done");
	endtask
	task automatic test_security;
		wr(`RTOS_OFS_FLTCFG, 32'h1);
		wr(`RTOS_OFS_SEC, 32'h05);
		wr(`RTOS_OFS_PDIR, 32'h0);
		wr(`RTOS_OFS_PMC, 32'h3F);
		wr(`RTOS_OFS_PPU, 32'h3F);
		repeat (2) @(posedge clk);
		check({26'h0, pinOe}, 32'h3F);
		check({26'h0, pinOut}, 32'h3F);
		check({26'h0, pinPu}, 32'h3F);
		flt <= 1'b1;
		repeat (3) @(posedge clk);
		check({31'h0, fault}, 32'h1);
		check({26'h0, pinOe}, 32'h0);
		check({26'h0, pinPu}, 32'h0);
		apb(1'b0, `RTOS_OFS_STAT, 32'h0);
		check(rd & 32'h003F_0001, 32'h0000_0001);
		wr(`RTOS_OFS_PMC, 32'h3F);
		rdc(`RTOS_OFS_PMC, 32'h0);
		rdc(`RTOS_OFS_PPU, 32'h0);
		rdc(`RTOS_OFS_PDIR, 32'h3F);
		wr(`RTOS_OFS_SEC, 32'h01);
		@(posedge clk);
		check({31'h0, fault}, 32'h0);
		wr(`RTOS_OFS_PMC, 32'h3F);
		rdc(`RTOS_OFS_PMC, 32'h3F);
		flt <= 1'b0;
		repeat (3) @(posedge clk);
		flt <= 1'b1;
		repeat (3) @(posedge clk);
		check({31'h0, fault}, 32'h0);
		$display("security done");
	endtask
	task automatic printVerdict;
		$display("compared %0d failed %0d", nCompared, nFail);
		if (nFail == 0 && nCompared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		test_regs();
		test_direct();
		test_triggers();
		test_edge();
		test_security();
		printVerdict();
	end
	initial begin
		#2000000;
		nFail++;
		printVerdict();
	end
endmodule
